// *** design/dts_pkg.sv ***
/*
  Constants for the diagnostic test sequencer: test numbers, timing counts,
  register map for the AXI4-Lite slave.
  Assumes a 10 MHz system clock.
*/
package dts_pkg;
  localparam int CLK_HZ = 10000000;
  localparam int TOGGLE_HZ = 1;
  localparam int HALF_PERIOD_CYC = CLK_HZ / (2 * TOGGLE_HZ);
  localparam int TRIG_PERIOD_NS = 90000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int TRIG_PERIOD_CYC = TRIG_PERIOD_NS / CLK_PERIOD_NS;
  localparam int CE_COUNT = 8;
  localparam int CE_SLOT_CYC = TRIG_PERIOD_CYC / CE_COUNT;
  localparam int DEBOUNCE_CYC = 100;
  localparam int STEP_CYC_DEFAULT = 5000000;
  localparam int ALTERNATIONS = 8;
  localparam logic [2:0] LAST_TEST = 3'h7;
  localparam logic [2:0] TEST_INPUT_LINES = 3'h5;
  localparam logic [3:0] PATTERN_STEPS = 4'hb;
  localparam int MEM_DEPTH = 16;
  localparam int MEM_AW = 4;
  localparam logic [7:0] MEM_PATTERN = 8'h55;
  localparam logic [4:0] FUNC_LED_MASK = 5'h1f;
  localparam logic [3:0] DIGIT_PASS = 4'h3;
  localparam logic [3:0] DIGIT_FAIL1 = 4'h1;
  localparam logic [3:0] DIGIT_FAIL2 = 4'h2;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CHECKSUM = 8'h08;
  localparam int CTRL_HOLD_BIT = 0;
  localparam int CTRL_TRAP_BIT = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {DTS_NORMAL, DTS_RUN, DTS_DONE} dts_mode_type;
endpackage : dts_pkg

// *** design/dts_mem.sv ***
/*
  Small scratch memory exercised by the memory test.
  Single port, registered read data, one clock.
*/
`timescale 1ns/10ps
module dts_mem (
  input wire logic aclk,
  input wire logic we,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:15];

  always_ff @(posedge aclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule : dts_mem

// *** design/dts_sequencer.sv ***
/*
  Diagnostic test sequencer: steps tests 0..7, drives display, LEDs,
  buzzer, trigger and chip-enable outputs; AXI4-Lite status/control.
  Assumes key, hold and trap inputs are asynchronous pins; one clock.
*/
// Notes on behaviour
// - Channel key held at power-up starts diagnostics
// - Trap pulse starts diagnostics from any state
// - Tests ascend, halt after test seven
// - Show test number on exponent digit
// - Stop key or hold pauses current test
// - Reset after test seven selects code_error_mode_2m
// - Reset with channel restarts at test zero when no test is running
// - Test zero LEDs toggle at 1 Hz, antiphase
// - Eighth alternation buzzes, then test one
// - Stop or hold repeats test zero
// - Test one trigger pulse every 90 us
// - Chip enables pulse low in order
// - Test two walks eleven patterns, holdable
// - Memory test pattern, complement, pass/fail digit
// - Program checksums per half modulo 256
// - Reset plus lamp test advances later tests
`timescale 1ns/10ps
module dts_sequencer #(
  parameter int STEP_CYC = dts_pkg::STEP_CYC_DEFAULT,
  parameter int HALF_CYC = dts_pkg::HALF_PERIOD_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic channel_key,
  input wire logic stop_key,
  input wire logic reset_key,
  input wire logic lamp_test_key,
  input wire logic hold_input,
  input wire logic trap_input,
  input wire logic [7:0] rom_byte,
  output logic [11:0] rom_addr,
  output logic [2:0] exponent_digit,
  output logic [3:0] digit_f,
  output logic [23:0] digits_a_f,
  output logic [4:0] function_leds,
  output logic other_leds,
  output logic buzzer,
  output logic serial_trigger_output,
  output logic [7:0] chip_enable_n,
  output logic [3:0] pen_pattern,
  output logic code_error_mode_2m,
  output logic diag_active,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // Inputs: channel, stop, reset, lamp, hold, trap
  logic [5:0] sync1_reg, sync2_reg, deb_reg, deb_prev_reg;
  logic [6:0] deb_cnt_reg;
  logic [5:0] raw;
  logic ch, stp, rst_k, lamp, hold_in, trap_in;
  logic pause, trap_rise, reset_rise, advance_rise, step_on;
  logic sw_hold_reg, sw_trap_reg, sw_trap_prev_reg;
  logic started_reg;
  dts_pkg::dts_mode_type mode_reg;
  logic [2:0] test_reg;
  logic [31:0] cnt_reg;
  logic [3:0] alt_reg;
  logic led_phase_reg;
  logic [3:0] step_reg;
  logic [1:0] mem_phase_reg;
  logic [3:0] mem_addr_reg;
  logic mem_we_reg, mem_check_reg;
  logic [7:0] mem_rdata;
  logic [7:0] sum_lo_reg, sum_hi_reg;
  logic rom_end_reg;
  logic test_done;

  function automatic logic [7:0] pattern_for(input logic [1:0] phase);
    pattern_for = phase[1] ? ~dts_pkg::MEM_PATTERN : dts_pkg::MEM_PATTERN;
  endfunction : pattern_for

  assign raw = {trap_input, hold_input, lamp_test_key, reset_key, stop_key, channel_key};

  // Two-stage sync, then debounce; the first stage feeds only the second
  always_ff @(posedge aclk) begin
    sync1_reg <= raw;
    sync2_reg <= sync1_reg;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // A key held through reset counts as settled, so the strap is seen at once
      deb_reg <= sync2_reg;
      deb_prev_reg <= sync2_reg;
      deb_cnt_reg <= 7'h00;
    end else begin
      deb_prev_reg <= deb_reg;
      if (sync2_reg == deb_reg) begin
        deb_cnt_reg <= 7'h00;
      end else if (deb_cnt_reg == 7'(dts_pkg::DEBOUNCE_CYC - 1)) begin
        deb_reg <= sync2_reg;
        deb_cnt_reg <= 7'h00;
      end else begin
        deb_cnt_reg <= deb_cnt_reg + 7'h01;
      end
    end
  end

  assign {trap_in, hold_in, lamp, rst_k, stp, ch} = deb_reg;
  assign pause = stp | hold_in | sw_hold_reg;
  assign trap_rise = (trap_in & ~deb_prev_reg[5]) | (sw_trap_reg & ~sw_trap_prev_reg);
  assign reset_rise = rst_k & ~deb_prev_reg[2];
  assign advance_rise = rst_k & lamp & ~(deb_prev_reg[2] & deb_prev_reg[3]);
  assign step_on = test_reg >= dts_pkg::TEST_INPUT_LINES && advance_rise;

  // Test completion per test
  always_comb begin
    test_done = 1'b0;
    unique case (test_reg)
      3'h0: test_done = (alt_reg == 4'(dts_pkg::ALTERNATIONS)) && !pause;
      // Test one's timebase wraps every trigger period, so it ends on a boundary
      3'h1: test_done = (cnt_reg == 32'(dts_pkg::TRIG_PERIOD_CYC - 1)) && !pause;
      // Compare is not exact: a hold that spans the end must still resume
      3'h6, 3'h7: test_done = (cnt_reg >= 32'(STEP_CYC - 1)) && !pause;
      3'h2: test_done = (step_reg == dts_pkg::PATTERN_STEPS)
                        && (cnt_reg == 32'(STEP_CYC - 1)) && !pause;
      3'h3: test_done = (mem_phase_reg == 2'h3) && !pause;
      3'h4: test_done = rom_end_reg && !pause;
      3'h5: test_done = 1'b0;
    endcase
  end

  // Sequencer state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= dts_pkg::DTS_NORMAL;
      test_reg <= 3'h0;
      started_reg <= 1'b0;
    end else begin
      started_reg <= 1'b1;
      if (!started_reg && ch) begin
        mode_reg <= dts_pkg::DTS_RUN;
        test_reg <= 3'h0;
      end else if (trap_rise) begin
        mode_reg <= dts_pkg::DTS_RUN;
        test_reg <= 3'h0;
      end else if (reset_rise && ch && mode_reg != dts_pkg::DTS_RUN) begin
        mode_reg <= dts_pkg::DTS_RUN;
        test_reg <= 3'h0;
      end else if (mode_reg == dts_pkg::DTS_DONE && reset_rise) begin
        mode_reg <= dts_pkg::DTS_NORMAL;
      end else if (mode_reg == dts_pkg::DTS_RUN) begin
        if (step_on) begin
          if (test_reg == dts_pkg::LAST_TEST) begin
            mode_reg <= dts_pkg::DTS_DONE;
          end else begin
            test_reg <= test_reg + 3'h1;
          end
        end else if (test_done) begin
          if (test_reg == dts_pkg::LAST_TEST) begin
            mode_reg <= dts_pkg::DTS_DONE;
          end else begin
            test_reg <= test_reg + 3'h1;
          end
        end
      end
    end
  end

  logic test_change;
  assign test_change = (mode_reg != dts_pkg::DTS_RUN) || test_done || trap_rise || step_on;

  // Per-test timebase
  always_ff @(posedge aclk) begin
    if (!aresetn || test_change) begin
      cnt_reg <= 32'h0;
    end else if (test_reg == 3'h0 && cnt_reg == 32'(HALF_CYC - 1)) begin
      cnt_reg <= 32'h0;
    end else if (test_reg == 3'h1 && cnt_reg == 32'(dts_pkg::TRIG_PERIOD_CYC - 1)) begin
      cnt_reg <= 32'h0;
    end else if ((test_reg == 3'h2) && cnt_reg == 32'(STEP_CYC - 1)) begin
      cnt_reg <= 32'h0;
    end else begin
      cnt_reg <= cnt_reg + 32'h1;
    end
  end

  // Test 0: LED alternation
  always_ff @(posedge aclk) begin
    if (!aresetn || test_change || test_reg != 3'h0) begin
      alt_reg <= 4'h0;
      led_phase_reg <= 1'b0;
    end else if (cnt_reg == 32'(HALF_CYC - 1)) begin
      led_phase_reg <= ~led_phase_reg;
      if (alt_reg == 4'(dts_pkg::ALTERNATIONS)) begin
        alt_reg <= 4'h1;
      end else begin
        alt_reg <= alt_reg + 4'h1;
      end
    end
  end

  // Test 2: pattern step, frozen while paused
  always_ff @(posedge aclk) begin
    if (!aresetn || test_reg != 3'h2 || mode_reg != dts_pkg::DTS_RUN) begin
      step_reg <= 4'h1;
    end else if (cnt_reg == 32'(STEP_CYC - 1) && !pause
                 && step_reg != dts_pkg::PATTERN_STEPS) begin
      step_reg <= step_reg + 4'h1;
    end
  end

  // Test 3: write pattern, verify, write complement, verify
  always_ff @(posedge aclk) begin
    if (!aresetn || test_reg != 3'h3 || mode_reg != dts_pkg::DTS_RUN) begin
      mem_phase_reg <= 2'h0;
      mem_addr_reg <= 4'h0;
      mem_we_reg <= 1'b1;
      mem_check_reg <= 1'b0;
      // The verdict stays shown after the test until the sequence starts over
      if (!aresetn || test_reg < 3'h3) begin
        digit_f <= 4'h0;
      end
    end else if (mem_phase_reg != 2'h3) begin
      if (mem_check_reg && mem_rdata != pattern_for(mem_phase_reg)) begin
        digit_f <= mem_phase_reg[1] ? dts_pkg::DIGIT_FAIL2 : dts_pkg::DIGIT_FAIL1;
        mem_phase_reg <= 2'h3;
      end else if (mem_we_reg) begin
        if (mem_addr_reg == 4'hf) begin
          mem_we_reg <= 1'b0;
        end
        mem_addr_reg <= mem_addr_reg + 4'h1;
      end else begin
        mem_check_reg <= 1'b1;
        if (mem_check_reg && mem_addr_reg == 4'h0) begin
          mem_check_reg <= 1'b0;
          if (mem_phase_reg[1]) begin
            mem_phase_reg <= 2'h3;
            digit_f <= dts_pkg::DIGIT_PASS;
          end else begin
            mem_phase_reg <= 2'h2;
            mem_we_reg <= 1'b1;
          end
        end else begin
          mem_addr_reg <= mem_addr_reg + 4'h1;
        end
      end
    end
  end

  dts_mem u_mem (
    .aclk(aclk),
    .we(mem_we_reg),
    .addr(mem_addr_reg),
    .wdata(pattern_for(mem_phase_reg)),
    .rdata(mem_rdata)
  );

  // Test 4: checksum each half of the program memory; the last byte counts too
  always_ff @(posedge aclk) begin
    if (!aresetn || test_reg != 3'h4 || mode_reg != dts_pkg::DTS_RUN) begin
      rom_addr <= 12'h000;
      rom_end_reg <= 1'b0;
    end else if (!rom_end_reg) begin
      if (rom_addr == 12'hfff) begin
        rom_end_reg <= 1'b1;
      end else begin
        rom_addr <= rom_addr + 12'h001;
      end
    end
  end

  // Sums stay readable over the bus once the test has moved on
  always_ff @(posedge aclk) begin
    if (!aresetn || test_reg < 3'h4) begin
      sum_lo_reg <= 8'h00;
      sum_hi_reg <= 8'h00;
    end else if (test_reg == 3'h4 && mode_reg == dts_pkg::DTS_RUN && !rom_end_reg) begin
      if (rom_addr[11]) begin
        sum_hi_reg <= sum_hi_reg + rom_byte;
      end else begin
        sum_lo_reg <= sum_lo_reg + rom_byte;
      end
    end
  end

  // Front-panel outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      exponent_digit <= 3'h0;
      digits_a_f <= 24'h0;
      function_leds <= 5'h00;
      other_leds <= 1'b0;
      buzzer <= 1'b0;
      serial_trigger_output <= 1'b0;
      chip_enable_n <= 8'hff;
      pen_pattern <= 4'hf;
      code_error_mode_2m <= 1'b0;
      diag_active <= 1'b0;
    end else begin
      diag_active <= mode_reg != dts_pkg::DTS_NORMAL;
      exponent_digit <= test_reg;
      code_error_mode_2m <= mode_reg == dts_pkg::DTS_NORMAL;
      buzzer <= test_reg == 3'h0 && alt_reg == 4'(dts_pkg::ALTERNATIONS);
      serial_trigger_output <= test_reg == 3'h1 && cnt_reg == 32'h0;
      chip_enable_n <= 8'hff;
      if (test_reg == 3'h1 && mode_reg == dts_pkg::DTS_RUN) begin
        chip_enable_n[cnt_reg[2 +: 3]] <= ~(cnt_reg[31:5] == 27'h0 && cnt_reg[1:0] == 2'h1);
      end
      pen_pattern <= test_reg == 3'h2 ? ~step_reg : 4'hf;
      if (test_reg == 3'h0) begin
        other_leds <= led_phase_reg;
        function_leds <= led_phase_reg ? 5'h00 : dts_pkg::FUNC_LED_MASK;
      end else begin
        other_leds <= test_reg == 3'h1;
        function_leds <= 5'h00;
      end
      digits_a_f <= test_reg == 3'h4 ? {8'h00, sum_hi_reg, sum_lo_reg} : {20'h0, digit_f};
    end
  end

  // AXI4-Lite slave
  logic aw_got_reg, w_got_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic w_strb0_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0;
      w_strb0_reg <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= dts_pkg::RESP_OKAY;
      sw_hold_reg <= 1'b0;
      sw_trap_reg <= 1'b0;
      sw_trap_prev_reg <= 1'b0;
    end else begin
      sw_trap_prev_reg <= sw_trap_reg;
      s_axi_awready <= !aw_got_reg && !s_axi_awready && !s_axi_bvalid && s_axi_awvalid;
      s_axi_wready <= !w_got_reg && !s_axi_wready && !s_axi_bvalid && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb0_reg <= s_axi_wstrb[0];
      end
      if (aw_got_reg && w_got_reg) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr_reg[7:2] == dts_pkg::ADDR_CTRL[7:2]) begin
          s_axi_bresp <= dts_pkg::RESP_OKAY;
          if (w_strb0_reg) begin
            sw_hold_reg <= w_data_reg[dts_pkg::CTRL_HOLD_BIT];
            sw_trap_reg <= w_data_reg[dts_pkg::CTRL_TRAP_BIT];
          end
        end else begin
          s_axi_bresp <= dts_pkg::RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        sw_trap_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= dts_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= dts_pkg::RESP_OKAY;
        unique case (s_axi_araddr[7:2])
          dts_pkg::ADDR_CTRL[7:2]: s_axi_rdata <= {30'h0, sw_trap_reg, sw_hold_reg};
          dts_pkg::ADDR_STATUS[7:2]: s_axi_rdata <= {20'h0, digit_f, 1'b0, test_reg,
                                                     pause, 1'b0, mode_reg};
          dts_pkg::ADDR_CHECKSUM[7:2]: s_axi_rdata <= {16'h0, sum_hi_reg, sum_lo_reg};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= dts_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : dts_sequencer

// *** verification/dts_sequencer_chk.sv ***
/*
  Checker for dts_sequencer: LED phase, trigger timing, chip enables, test order, bus answers.
  Bound to every dts_sequencer instance; sees only its ports.
*/
`timescale 1ns/10ps
module dts_sequencer_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [2:0] exponent_digit,
  input wire logic [4:0] function_leds,
  input wire logic other_leds,
  input wire logic serial_trigger_output,
  input wire logic [7:0] chip_enable_n,
  input wire logic code_error_mode_2m,
  input wire logic diag_active,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic [11:0] trig_cnt_reg;
  logic trig_arm_reg;
  // Period is judged only between two pulses seen within one stay in test one
  always_ff @(posedge aclk) begin
    if (!aresetn || !diag_active || exponent_digit != 3'h1) begin
      trig_cnt_reg <= 12'h000;
      trig_arm_reg <= 1'b0;
    end else if (serial_trigger_output) begin
      trig_cnt_reg <= 12'h001;
      trig_arm_reg <= 1'b1;
    end else if (trig_cnt_reg != 12'hfff) begin
      trig_cnt_reg <= trig_cnt_reg + 12'h001;
    end
  end
  chk_led_antiphase: assert property (
    diag_active && exponent_digit == 3'h0 && $past(diag_active) && $past(exponent_digit) == 3'h0
    |-> function_leds == {5{~other_leds}}) else $error("LED groups not in antiphase");
  chk_trig_period: assert property (serial_trigger_output && trig_arm_reg
    |-> trig_cnt_reg == 12'(dts_pkg::TRIG_PERIOD_CYC)) else $error("trigger period wrong");
  chk_trig_width: assert property ($rose(serial_trigger_output)
    |=> !serial_trigger_output [*8]) else $error("trigger pulse too long");
  chk_trig_in_t1: assert property (serial_trigger_output
    |-> diag_active && exponent_digit == 3'h1) else $error("trigger outside test one");
  chk_ce_single: assert property (chip_enable_n != 8'hff
    |-> $onehot(~chip_enable_n) && exponent_digit == 3'h1) else $error("chip enable misuse");
  chk_test_ascend: assert property (
    diag_active && $past(diag_active) && exponent_digit != $past(exponent_digit)
    |-> exponent_digit == $past(exponent_digit) + 3'h1 || exponent_digit == 3'h0)
    else $error("test order broken");
  chk_normal_excl: assert property (code_error_mode_2m |-> !diag_active)
    else $error("normal mode during diagnostics");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
endmodule : dts_sequencer_chk

bind dts_sequencer dts_sequencer_chk chk_inst (.aclk, .aresetn, .exponent_digit,
  .function_leds, .other_leds, .serial_trigger_output, .chip_enable_n, .code_error_mode_2m,
  .diag_active, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_bvalid, .s_axi_bready);

// *** verification/dts_panel_model.sv ***
/*
  Front-panel keys and technician probes: bench key commands become contact levels.
  Assumes key_cmd changes just after clock edges; bit order is channel, stop, reset,
  lamp test, hold, trap.
*/
`timescale 1ns/10ps
module dts_panel_model (
  input wire logic aclk,
  input wire logic [5:0] key_cmd,
  output logic channel_key,
  output logic stop_key,
  output logic reset_key,
  output logic lamp_test_key,
  output logic hold_input,
  output logic trap_input
);
  logic [5:0] prev_reg = 6'h00;
  logic [5:0] chg_reg = 6'h00;
  logic [5:0] lvl_reg = 6'h00;
  logic [2:0] bounce_reg = 3'h0;
  // Changed contacts chatter for six cycles so a missing debouncer shows up
  always_ff @(posedge aclk) begin
    prev_reg <= key_cmd;
    if (key_cmd != prev_reg) begin
      chg_reg <= key_cmd ^ prev_reg;
      bounce_reg <= 3'h6;
    end else if (bounce_reg != 3'h0) begin
      bounce_reg <= bounce_reg - 3'h1;
    end
    lvl_reg <= bounce_reg[0] ? key_cmd ^ chg_reg : key_cmd;
  end
  assign channel_key = lvl_reg[0];
  assign stop_key = lvl_reg[1];
  assign reset_key = lvl_reg[2];
  assign lamp_test_key = lvl_reg[3];
  assign hold_input = lvl_reg[4];
  assign trap_input = lvl_reg[5];
endmodule : dts_panel_model

// *** verification/dts_sequencer_tb.sv ***
/*
  Testbench for dts_sequencer: entry by trap and strap, holds, test walk, exit, bus.
  Assumes the panel model and the bound checker are compiled with it.
*/
`timescale 1ns/10ps
module dts_sequencer_tb;
  logic aclk, aresetn, channel_key, stop_key, reset_key, lamp_test_key, hold_input, trap_input;
  logic [5:0] key_cmd;
  logic [7:0] rom_byte, chip_enable_n, s_axi_awaddr, s_axi_araddr;
  logic [11:0] rom_addr;
  logic [2:0] exponent_digit;
  logic [3:0] digit_f, pen_pattern, s_axi_wstrb;
  logic [23:0] digits_a_f;
  logic [4:0] function_leds;
  logic other_leds, buzzer, serial_trigger_output, code_error_mode_2m, diag_active;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  int err_total, n_tests, i;
  logic [7:0] s_lo, s_hi, rb;
  assign rom_byte = rom_addr[7:0] ^ rom_addr[11:4];
  dts_panel_model dts_panel_model_inst (.aclk, .key_cmd, .channel_key, .stop_key, .reset_key,
    .lamp_test_key, .hold_input, .trap_input);
  // Short counts keep test zero and the timed tests to a few hundred cycles
  dts_sequencer #(.STEP_CYC(50), .HALF_CYC(20)) dts_sequencer_inst (.aclk, .aresetn,
    .channel_key, .stop_key, .reset_key, .lamp_test_key, .hold_input, .trap_input, .rom_byte,
    .rom_addr, .exponent_digit, .digit_f, .digits_a_f, .function_leds, .other_leds, .buzzer,
    .serial_trigger_output, .chip_enable_n, .pen_pattern, .code_error_mode_2m, .diag_active,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done
  task automatic press(input logic [5:0] m, input int n);
    @(posedge aclk);
    key_cmd <= m;
    repeat (n) @(posedge aclk);
  endtask : press
  task automatic wait_digit(input logic [2:0] d);
    for (int k = 0; k < 20000 && exponent_digit !== d; k++) @(posedge aclk);
    check("test number", exponent_digit, d);
  endtask : wait_digit
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    check("write resp", s_axi_bresp, dts_pkg::RESP_OKAY);
    s_axi_bready <= 1'b0;
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_read
  initial begin
    repeat (60000) @(posedge aclk);
    err_total++;
    test_done();
  end
  initial begin
    aresetn = 1'b0;
    key_cmd = 6'h00;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    err_total = 0;
    n_tests = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    check("diag idle", diag_active, 1'b0);
    check("normal mode", code_error_mode_2m, 1'b1);
    $display("test power-up done");
    press(6'h22, 150);
    check("diag after trap", diag_active, 1'b1);
    press(6'h02, 400);
    check("test zero repeats", exponent_digit, 3'h0);
    for (i = 0; i < 200 && buzzer !== 1'b1; i++) @(posedge aclk);
    check("buzzer", buzzer, 1'b1);
    press(6'h00, 1);
    wait_digit(3'h1);
    axi_write(dts_pkg::ADDR_CTRL, 32'h1);
    press(6'h10, 150);
    axi_write(dts_pkg::ADDR_CTRL, 32'h0);
    for (i = 0; i < 2000 && serial_trigger_output !== 1'b1; i++) @(posedge aclk);
    @(posedge aclk);
    for (i = 1; i < 2000 && serial_trigger_output !== 1'b1; i++) @(posedge aclk);
    check("trigger period", i, dts_pkg::TRIG_PERIOD_CYC);
    check("held in test one", exponent_digit, 3'h1);
    $display("test entry and hold done");
    press(6'h00, 1);
    wait_digit(3'h4);
    check("memory result", digit_f, dts_pkg::DIGIT_PASS);
    wait_digit(3'h5);
    check("digit F shown", digits_a_f, 24'h3);
    press(6'h00, 300);
    check("input test waits", exponent_digit, 3'h5);
    press(6'h0c, 150);
    press(6'h00, 1);
    wait_digit(3'h6);
    wait_digit(3'h7);
    repeat (300) @(posedge aclk);
    axi_read(dts_pkg::ADDR_STATUS, rd, rs);
    check("done mode", rd & 32'h3, 32'h2);
    check("halted at seven", exponent_digit, 3'h7);
    check("status resp", rs, dts_pkg::RESP_OKAY);
    s_lo = 8'h00;
    s_hi = 8'h00;
    for (i = 0; i < 4096; i++) begin
      rb = 8'(i) ^ 8'(i >> 4);
      if (i < 2048) begin
        s_lo += rb;
      end else begin
        s_hi += rb;
      end
    end
    axi_read(dts_pkg::ADDR_CHECKSUM, rd, rs);
    check("checksums", rd, {16'h0, s_hi, s_lo});
    axi_read(8'h0c, rd, rs);
    check("unmapped resp", rs, dts_pkg::RESP_SLVERR);
    check("unmapped data", rd, 32'h0);
    $display("test walk done");
    press(6'h04, 150);
    press(6'h00, 150);
    check("back to normal", code_error_mode_2m, 1'b1);
    check("diag ended", diag_active, 1'b0);
    press(6'h05, 150);
    check("restart active", diag_active, 1'b1);
    check("restart at zero", exponent_digit, 3'h0);
    press(6'h01, 150);
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (5) @(posedge aclk);
    check("strap entry", diag_active, 1'b1);
    $display("test exit and restart done");
    test_done();
  end
endmodule : dts_sequencer_tb
